// ---- hdl/csmb_pkg.sv ----
// Purpose: Shared constants and types for the configuration broadcast link
// Assumes: Single 20 MHz ref_clk domain shared by both ends
// Notes:   Rules bind both ends of the link
// Contract
// - Status bit 0 is secondary status bit 4
// - Slot events used only in root slot mode
// - Endpoint side ties all slot events low
// - Bit 0 is attention button, else tied low
// - Bit 1 flags card presence change
// - Bit 2 flags retention latch open
// - No latch sensor: bit 2 tied low
// - Bit 3 flags slot power fault
// - No power controller: bits 3,4 low
// - Bit 4 mirrors power control, sets completion
// - Slots 0-2: device, slot, link control words
// - Slots presented round robin with index
// - Slots 3-7: bridge, bus, window words
// - Slots 8-F: prefetch, power, message, map, bus/device
// - Slot 0 upper half holds size fields
// - Outputs refresh on every clock cycle
// - Index is four bits, names current slot
// - Size codes 0-5 mean 128-4096 bytes
package csmb_pkg;

  // ----------------------------------------------------------------
  // Link widths and slot indices
  // ----------------------------------------------------------------
  localparam int IDX_W  = 4;
  localparam int WORD_W = 32;
  localparam int STS_W  = 53;
  localparam int EVT_W  = 5;

  localparam logic [IDX_W-1:0] IDX_DEV = 4'h0, IDX_SLOT = 4'h1, IDX_LINK = 4'h2,
    IDX_PRIM = 4'h3, IDX_BUS = 4'h4, IDX_IO_BASE = 4'h5, IDX_IO_LIM = 4'h6,
    IDX_NP = 4'h7, IDX_PF_BASE_LO = 4'h8, IDX_PF_BASE_HI = 4'h9,
    IDX_PF_LIM_LO = 4'hA, IDX_PF_LIM_HI = 4'hB, IDX_PM = 4'hC, IDX_MSG = 4'hD,
    IDX_TC = 4'hE, IDX_BUSDEV = 4'hF;

  // ----------------------------------------------------------------
  // Slot event bits and sticky slot status bits
  // ----------------------------------------------------------------
  localparam int EV_BUTTON = 0, EV_PRESENCE = 1, EV_LATCH = 2, EV_FAULT = 3, EV_PWR_CTL = 4;
  localparam int SS_BUTTON = 0, SS_FAULT = 1, SS_LATCH = 2, SS_PRESENCE = 3, SS_CMD_DONE = 4;
  localparam int STS_CMD_DONE = 47;
  localparam int STS_DLL_CHG  = 48;
  localparam int SLOT_DLL_CHG = 8;

  // Size field positions in device control and the decode
  localparam int MRRS_LSB = 12;
  localparam int MPS_LSB  = 5;
  localparam int SIZE_W   = 13;
  localparam logic [2:0] SIZE_CODE_MAX = 3'h5;
  localparam logic [SIZE_W-1:0] SIZE_BASE_BYTES = 13'h0080;

  // ----------------------------------------------------------------
  // Host register map (byte offsets) and fields
  // ----------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam logic [ADDR_W-1:0] OFF_SHADOW_END = 8'h40, OFF_STS_LO = 8'h40,
    OFF_STS_HI = 8'h44, OFF_IRQ_STS = 8'h48, OFF_IRQ_MASK = 8'h4C, OFF_CTL = 8'h50;
  localparam int CTL_W = 4;
  localparam int CTL_ROOT = 0, CTL_BTN = 1, CTL_LATCH = 2, CTL_PWR = 3;
  localparam logic [CTL_W-1:0] CTL_RESET = 4'h0;
  localparam int IRQ_W = 3;
  localparam int IRQ_CMD_DONE = 0, IRQ_WORD_CHG = 1, IRQ_ROUND = 2;
  localparam logic [IRQ_W-1:0] IRQ_MASK_RESET = 3'h0;

  // Configuration contents the device broadcasts
  typedef struct packed {
    logic [31:0] dev_csr;
    logic [15:0] device_ctl_status_two;
    logic [15:0] slot_ctl;
    logic [15:0] slot_sts;
    logic [31:0] link_csr;
    logic [16:0] link_ctl_status_two;
    logic [31:0] prm_csr;
    logic [25:0] root_csr;
    logic [31:0] sec_csr;
    logic [7:0]  sec_bus;
    logic [7:0]  sub_bus;
    logic [19:0] io_base;
    logic [19:0] io_limit;
    logic [11:0] nonprefetch_base;
    logic [11:0] nonprefetch_limit;
    logic [43:0] prefetch_base;
    logic [43:0] prefetch_limit;
    logic [31:0] pm_csr;
    logic [15:0] extended_msg_irq_ctl;
    logic [15:0] msg_irq_ctl;
    logic [23:0] traffic_class_map;
    logic [12:0] bus_dev;
  } csmb_cfg_s;

endpackage

// ---- hdl/csmb_link_if.sv ----
// Purpose: Broadcast link between the configuration port and application
// Assumes: Both ends on the same ref_clk
// Notes:   No clocking block; bench joins the two ends here
`timescale 1ns/1ns
interface csmb_link_if;
  logic [csmb_pkg::IDX_W-1:0]  cfg_slot_index;
  logic [csmb_pkg::WORD_W-1:0] cfg_mux_word;
  logic [csmb_pkg::STS_W-1:0]  cfg_status_vector;
  logic [csmb_pkg::EVT_W-1:0]  slot_event;

  // Port end drives the broadcast, application end drives slot events
  modport dev  (output cfg_slot_index, output cfg_mux_word, output cfg_status_vector,
                input slot_event);
  modport host (input cfg_slot_index, input cfg_mux_word, input cfg_status_vector,
                output slot_event);
endinterface

// ---- hdl/csmb_dev.sv ----
// Purpose: Port end - broadcasts configuration contents round robin
// Assumes: slot_event comes from application logic on ref_clk
// Notes:   Sticky slot status bits are cleared by slot_sts_clear pulses
//
// Our own choices: register access over Avalon-MM and the address map.
`timescale 1ns/1ns
module csmb_dev (
  input  wire logic                            ref_clk,
  input  wire logic                            rst,
  csmb_link_if.dev                             link,
  input  wire csmb_pkg::csmb_cfg_s             cfg,
  input  wire logic                            root_port_mode,
  input  wire logic                            slot_cap_enable,
  input  wire logic [csmb_pkg::EVT_W-1:0]      slot_sts_clear,
  output logic      [csmb_pkg::EVT_W-1:0]      slot_sts,
  output logic      [csmb_pkg::SIZE_W-1:0]     max_read_req_bytes,
  output logic      [csmb_pkg::SIZE_W-1:0]     max_payload_bytes
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [csmb_pkg::IDX_W-1:0]  idx;
    logic [csmb_pkg::WORD_W-1:0] word;
    logic [csmb_pkg::STS_W-1:0]  sts;
    logic [csmb_pkg::EVT_W-1:0]  prev;
    logic [csmb_pkg::EVT_W-1:0]  slot_sts;
    logic [csmb_pkg::SIZE_W-1:0] mrrs;
    logic [csmb_pkg::SIZE_W-1:0] mps;
  } csmb_dev_state_s;

  csmb_dev_state_s s_reg;
  csmb_dev_state_s s_next;

  logic [csmb_pkg::EVT_W-1:0] evt;
  logic [csmb_pkg::EVT_W-1:0] rise;
  logic [csmb_pkg::EVT_W-1:0] chg;
  logic [csmb_pkg::EVT_W-1:0] set;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Size code to bytes; reserved codes read as zero
  function automatic logic [csmb_pkg::SIZE_W-1:0] size_bytes(input logic [2:0] code);
    logic [csmb_pkg::SIZE_W-1:0] r;
    r = '0;
    if (code <= csmb_pkg::SIZE_CODE_MAX) begin
      r = csmb_pkg::SIZE_BASE_BYTES << code;
    end
    return r;
  endfunction

  // Slot status with the hardware sticky bits spliced in
  function automatic logic [15:0] slot_status_word(
    input csmb_pkg::csmb_cfg_s         c,
    input logic [csmb_pkg::EVT_W-1:0]  ss
  );
    logic [15:0] r;
    r = c.slot_sts;
    r[csmb_pkg::EVT_W-1:0] = ss;
    return r;
  endfunction

  // Word presented for one slot index
  function automatic logic [csmb_pkg::WORD_W-1:0] word_for(
    input logic [csmb_pkg::IDX_W-1:0]  i,
    input csmb_pkg::csmb_cfg_s         c,
    input logic [csmb_pkg::EVT_W-1:0]  ss
  );
    logic [csmb_pkg::WORD_W-1:0] r;
    r = '0;
    case (i)
      csmb_pkg::IDX_DEV: begin
        // Upper half carries size fields 14:12 and 7:5 at word bits 30:28 and 23:21
        r = {c.dev_csr[15:0], c.device_ctl_status_two};
      end
      csmb_pkg::IDX_SLOT: begin
        r = {c.slot_ctl, slot_status_word(c, ss)};
      end
      csmb_pkg::IDX_LINK: begin
        r = {c.link_csr[15:0], c.link_ctl_status_two[15:0]};
      end
      csmb_pkg::IDX_PRIM: begin
        r = {8'h00, c.prm_csr[15:0], c.root_csr[7:0]};
      end
      csmb_pkg::IDX_BUS: begin
        r = {c.sec_csr[15:0], c.sec_bus, c.sub_bus};
      end
      csmb_pkg::IDX_IO_BASE: begin
        r = {12'h000, c.io_base};
      end
      csmb_pkg::IDX_IO_LIM: begin
        r = {12'h000, c.io_limit};
      end
      csmb_pkg::IDX_NP: begin
        r = {8'h00, c.nonprefetch_base, c.nonprefetch_limit};
      end
      csmb_pkg::IDX_PF_BASE_LO: begin
        r = c.prefetch_base[31:0];
      end
      csmb_pkg::IDX_PF_BASE_HI: begin
        r = {20'h00000, c.prefetch_base[43:32]};
      end
      csmb_pkg::IDX_PF_LIM_LO: begin
        r = c.prefetch_limit[31:0];
      end
      csmb_pkg::IDX_PF_LIM_HI: begin
        r = {20'h00000, c.prefetch_limit[43:32]};
      end
      csmb_pkg::IDX_PM: begin
        r = c.pm_csr;
      end
      csmb_pkg::IDX_MSG: begin
        r = {c.extended_msg_irq_ctl, c.msg_irq_ctl};
      end
      csmb_pkg::IDX_TC: begin
        r = {8'h00, c.traffic_class_map};
      end
      csmb_pkg::IDX_BUSDEV: begin
        r = {16'h0000, 3'h0, c.bus_dev};
      end
      // Unreachable: all sixteen indices are decoded above
      default: begin
        r = '0;
      end
    endcase
    return r;
  endfunction

  // Status vector, most significant group first
  function automatic logic [csmb_pkg::STS_W-1:0] status_for(
    input csmb_pkg::csmb_cfg_s         c,
    input logic [csmb_pkg::EVT_W-1:0]  ss
  );
    logic [csmb_pkg::STS_W-1:0] r;
    r = {
      c.dev_csr[19:16],
      c.slot_sts[csmb_pkg::SLOT_DLL_CHG],
      ss[csmb_pkg::SS_CMD_DONE],
      c.link_csr[31:16],
      c.link_ctl_status_two[16],
      c.prm_csr[31:27],
      c.prm_csr[24],
      c.root_csr[25:8],
      c.sec_csr[31:27],
      c.sec_csr[4]
    };
    return r;
  endfunction

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  // Slot events count only in root mode with the slot enabled;
  // elsewhere a floating or stray input must not set status
  always_comb begin
    s_next = s_reg;
    evt    = (root_port_mode && slot_cap_enable) ? link.slot_event : '0;
    rise   = evt & ~s_reg.prev;
    chg    = evt ^ s_reg.prev;
    set    = '0;
    set[csmb_pkg::SS_BUTTON]   = rise[csmb_pkg::EV_BUTTON];
    set[csmb_pkg::SS_FAULT]    = rise[csmb_pkg::EV_FAULT];
    set[csmb_pkg::SS_LATCH]    = chg[csmb_pkg::EV_LATCH];
    set[csmb_pkg::SS_PRESENCE] = rise[csmb_pkg::EV_PRESENCE];
    // Any move of the power control mirror completes the command
    set[csmb_pkg::SS_CMD_DONE] = chg[csmb_pkg::EV_PWR_CTL];
    s_next.prev = evt;
    // Set wins over a clear arriving in the same cycle
    s_next.slot_sts = (s_reg.slot_sts & ~slot_sts_clear) | set;
    // Four-bit counter wraps F to 0 by itself
    s_next.idx  = s_reg.idx + 4'h1;
    // Word tracks the index it is labelled with
    s_next.word = word_for(s_next.idx, cfg, s_next.slot_sts);
    s_next.sts  = status_for(cfg, s_next.slot_sts);
    s_next.mrrs = size_bytes(cfg.dev_csr[csmb_pkg::MRRS_LSB +: 3]);
    s_next.mps  = size_bytes(cfg.dev_csr[csmb_pkg::MPS_LSB +: 3]);
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  // Every output comes straight from this register
  // Sync reset only: the link shows index 0 and word 0 until the
  // first edge after release, so a watcher must skip one cycle
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // Link outputs
  assign link.cfg_slot_index    = s_reg.idx;
  assign link.cfg_mux_word      = s_reg.word;
  assign link.cfg_status_vector = s_reg.sts;

  // User-side outputs
  assign slot_sts           = s_reg.slot_sts;
  assign max_read_req_bytes = s_reg.mrrs;
  assign max_payload_bytes  = s_reg.mps;

endmodule

// ---- hdl/csmb_host.sv ----
// Purpose: Application end - shadows the broadcast, drives slot events
// Assumes: Slot hardware pins are asynchronous; Avalon-MM slave on ref_clk
// Notes:   One wait state per access; irq is a level
`timescale 1ns/1ns
module csmb_host (
  input  wire logic                          ref_clk,
  input  wire logic                          rst,
  csmb_link_if.host                          link,
  input  wire logic                          attention_button,
  input  wire logic                          presence_change,
  input  wire logic                          latch_open,
  input  wire logic                          power_fault,
  input  wire logic                          power_ctl_on,
  input  wire logic [csmb_pkg::ADDR_W-1:0]   avs_address,
  input  wire logic                          avs_read,
  input  wire logic                          avs_write,
  input  wire logic [31:0]                   avs_writedata,
  input  wire logic [3:0]                    avs_byteenable,
  output logic      [31:0]                   avs_readdata,
  output logic                               avs_waitrequest,
  output logic                               irq
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [15:0][csmb_pkg::WORD_W-1:0] shadow;
    logic [csmb_pkg::STS_W-1:0]        status;
    logic [csmb_pkg::EVT_W-1:0]        sync1;
    logic [csmb_pkg::EVT_W-1:0]        sync2;
    logic [csmb_pkg::EVT_W-1:0]        evt;
    logic [csmb_pkg::CTL_W-1:0]        ctl;
    logic [csmb_pkg::IRQ_W-1:0]        irq_sts;
    logic [csmb_pkg::IRQ_W-1:0]        irq_mask;
    logic                              ack;
    logic [31:0]                       rdata;
  } csmb_host_state_s;

  csmb_host_state_s s_reg;
  csmb_host_state_s s_next;

  logic [31:0]                wmask;
  logic [csmb_pkg::IRQ_W-1:0] ev;
  logic [csmb_pkg::IRQ_W-1:0] clr;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Byte enables to a bit mask
  function automatic logic [31:0] be_mask(input logic [3:0] be);
    return {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
  endfunction

  // Slot events gated by slot mode and the fitted hardware
  function automatic logic [csmb_pkg::EVT_W-1:0] slot_evt_for(
    input logic [csmb_pkg::EVT_W-1:0] hw,
    input logic [csmb_pkg::CTL_W-1:0] c
  );
    logic [csmb_pkg::EVT_W-1:0] r;
    r = '0;
    if (c[csmb_pkg::CTL_ROOT]) begin
      r[csmb_pkg::EV_BUTTON]   = hw[csmb_pkg::EV_BUTTON] & c[csmb_pkg::CTL_BTN];
      r[csmb_pkg::EV_PRESENCE] = hw[csmb_pkg::EV_PRESENCE];
      r[csmb_pkg::EV_LATCH]    = hw[csmb_pkg::EV_LATCH] & c[csmb_pkg::CTL_LATCH];
      r[csmb_pkg::EV_FAULT]    = hw[csmb_pkg::EV_FAULT] & c[csmb_pkg::CTL_PWR];
      r[csmb_pkg::EV_PWR_CTL]  = hw[csmb_pkg::EV_PWR_CTL] & c[csmb_pkg::CTL_PWR];
    end
    return r;
  endfunction

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    s_next = s_reg;
    wmask  = be_mask(avs_byteenable);
    clr    = '0;
    // Pins cross in through two flops before any gating
    s_next.sync1 = {power_ctl_on, power_fault, latch_open, presence_change, attention_button};
    s_next.sync2 = s_reg.sync1;
    s_next.evt   = slot_evt_for(s_reg.sync2, s_reg.ctl);
    // Shadow whatever slot the port names this cycle
    s_next.shadow[link.cfg_slot_index] = link.cfg_mux_word;
    s_next.status = link.cfg_status_vector;
    ev = '0;
    ev[csmb_pkg::IRQ_CMD_DONE] = link.cfg_status_vector[csmb_pkg::STS_CMD_DONE]
                                 & ~s_reg.status[csmb_pkg::STS_CMD_DONE];
    ev[csmb_pkg::IRQ_WORD_CHG] = link.cfg_mux_word != s_reg.shadow[link.cfg_slot_index];
    ev[csmb_pkg::IRQ_ROUND]    = link.cfg_slot_index == csmb_pkg::IDX_BUSDEV;
    // One wait state: ack rises the cycle after a request appears
    s_next.ack = (avs_read || avs_write) && !s_reg.ack;
    if (avs_read && !s_reg.ack) begin
      s_next.rdata = 32'h00000000;
      if (avs_address < csmb_pkg::OFF_SHADOW_END) begin
        s_next.rdata = s_reg.shadow[avs_address[5:2]];
      end else begin
        case (avs_address)
          csmb_pkg::OFF_STS_LO:   s_next.rdata = s_reg.status[31:0];
          csmb_pkg::OFF_STS_HI:   s_next.rdata = {11'h000, s_reg.status[52:32]};
          csmb_pkg::OFF_IRQ_STS:  s_next.rdata = {29'h00000000, s_reg.irq_sts};
          csmb_pkg::OFF_IRQ_MASK: s_next.rdata = {29'h00000000, s_reg.irq_mask};
          csmb_pkg::OFF_CTL:      s_next.rdata = {28'h0000000, s_reg.ctl};
          default:                s_next.rdata = 32'h00000000;
        endcase
      end
    end
    // Writes land on the edge after ack rises, ending the access; unmapped ones vanish
    if (avs_write && s_reg.ack) begin
      case (avs_address)
        csmb_pkg::OFF_IRQ_STS: begin
          clr = avs_writedata[csmb_pkg::IRQ_W-1:0] & wmask[csmb_pkg::IRQ_W-1:0];
        end
        csmb_pkg::OFF_IRQ_MASK: begin
          s_next.irq_mask = (s_reg.irq_mask & ~wmask[csmb_pkg::IRQ_W-1:0])
                            | (avs_writedata[csmb_pkg::IRQ_W-1:0] & wmask[csmb_pkg::IRQ_W-1:0]);
        end
        csmb_pkg::OFF_CTL: begin
          s_next.ctl = (s_reg.ctl & ~wmask[csmb_pkg::CTL_W-1:0])
                       | (avs_writedata[csmb_pkg::CTL_W-1:0] & wmask[csmb_pkg::CTL_W-1:0]);
        end
        default: begin
          clr = '0;
        end
      endcase
    end
    // Set wins over a write-one clear in the same cycle
    s_next.irq_sts = (s_reg.irq_sts & ~clr) | ev;
  end

  // ----------------------------------------------------------------
  // Registers and outputs
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      s_reg          <= '0;
      s_reg.ctl      <= csmb_pkg::CTL_RESET;
      s_reg.irq_mask <= csmb_pkg::IRQ_MASK_RESET;
    end else begin
      s_reg <= s_next;
    end
  end

  // Outputs
  assign link.slot_event  = s_reg.evt;
  assign avs_readdata     = s_reg.rdata;
  assign avs_waitrequest  = !s_reg.ack;
  assign irq              = |(s_reg.irq_sts & s_reg.irq_mask);

endmodule

// ---- sim/csmb_link_assertions.sv ----
// Purpose: Watches the broadcast link between the two ends
// Assumes: One ref_clk domain, rst synchronous and active high
// Notes:   Interface signals arrive as plain inputs, no bind
`timescale 1ns/1ns
module csmb_link_assertions (
  input  wire logic                             ref_clk,
  input  wire logic                             rst,
  input  wire logic [csmb_pkg::IDX_W-1:0]       cfg_slot_index,
  input  wire logic [csmb_pkg::WORD_W-1:0]      cfg_mux_word,
  input  wire logic [csmb_pkg::STS_W-1:0]       cfg_status_vector,
  input  wire logic [csmb_pkg::EVT_W-1:0]       slot_event
);
  // ----------------------------------------------------------------
  // Link properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  // Steps of the wrap and of a power-control change
  sequence at_last;     cfg_slot_index == 4'hF; endsequence
  sequence at_first;    cfg_slot_index == 4'h0; endsequence
  sequence pwr_toggled; $past(slot_event[4]) != $past(slot_event[4], 2); endsequence

  // First cycle after reset still shows the reset index, so skip it
  idx_step_a: assert property (!$past(rst) |->
    cfg_slot_index == 4'($past(cfg_slot_index) + 4'h1)) else $error("index did not step");
  wrap_to_zero_a: assert property (at_last |=> at_first)
    else $error("index did not wrap");
  bridge_zero_a: assert property (cfg_slot_index == 4'h3 |-> cfg_mux_word[31:24] == 8'h00)
    else $error("slot 3 top byte not zero");
  io_zero_a: assert property ((cfg_slot_index == 4'h5 || cfg_slot_index == 4'h6) |->
    cfg_mux_word[31:20] == 12'h000) else $error("io window top bits not zero");
  window_zero_a: assert property (cfg_slot_index == 4'h7 |-> cfg_mux_word[31:24] == 8'h00)
    else $error("slot 7 top byte not zero");
  prefetch_zero_a: assert property ((cfg_slot_index == 4'h9 || cfg_slot_index == 4'hB) |->
    cfg_mux_word[31:12] == 20'h00000) else $error("prefetch upper word not zero padded");
  tc_zero_a: assert property (cfg_slot_index == 4'hE |-> cfg_mux_word[31:24] == 8'h00)
    else $error("slot E top byte not zero");
  busdev_zero_a: assert property (cfg_slot_index == 4'hF |->
    cfg_mux_word[31:13] == 19'h00000) else $error("slot F top bits not zero");
  // Completion flag may only rise one cycle after the mirror moved
  cmd_done_a: assert property ($rose(cfg_status_vector[csmb_pkg::STS_CMD_DONE]) |->
    pwr_toggled) else $error("command done rose without power control change");
endmodule

// ---- sim/test_config_space_mux_broadcast.sv ----
// Purpose: Self-checking bench joining port end and application end
// Assumes: 20 MHz ref_clk, rst held 10 cycles
// Notes:   Inputs change by non-blocking assignment after rising edges
`timescale 1ns/1ns
module test_config_space_mux_broadcast;
  logic                ref_clk;
  logic                rst;
  csmb_pkg::csmb_cfg_s cfg;
  logic                root_port_mode;
  logic                slot_cap_enable;
  logic [4:0]          ss_clear;
  logic [4:0]          ss;
  logic [4:0]          pins;
  logic [12:0]         mrrs;
  logic [12:0]         mps;
  logic [7:0]          avs_address;
  logic                avs_read;
  logic                avs_write;
  logic [31:0]         avs_writedata;
  logic [31:0]         avs_readdata;
  logic [31:0]         rd;
  logic                avs_waitrequest;
  logic                irq;
  int                  err_total = 0;
  int                  checked = 0;
  int                  cycles = 0;

  // ----------------------------------------------------------------
  // Both ends across one link, checker beside it
  // ----------------------------------------------------------------
  csmb_link_if link ();
  csmb_dev u_csmb_dev (.ref_clk(ref_clk), .rst(rst), .link(link.dev), .cfg(cfg),
    .root_port_mode(root_port_mode), .slot_cap_enable(slot_cap_enable),
    .slot_sts_clear(ss_clear), .slot_sts(ss), .max_read_req_bytes(mrrs),
    .max_payload_bytes(mps));
  csmb_host u_csmb_host (.ref_clk(ref_clk), .rst(rst), .link(link.host),
    .attention_button(pins[0]), .presence_change(pins[1]), .latch_open(pins[2]),
    .power_fault(pins[3]), .power_ctl_on(pins[4]), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(4'hF), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .irq(irq));
  csmb_link_assertions u_link_chk (.ref_clk(ref_clk), .rst(rst),
    .cfg_slot_index(link.cfg_slot_index), .cfg_mux_word(link.cfg_mux_word),
    .cfg_status_vector(link.cfg_status_vector), .slot_event(link.slot_event));

  // Clock and hang guard
  always #25 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == 4000) begin
      err_total++;
      end_of_test();
    end
  end

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
  endtask

  // Values read right after an edge are the settled pre-edge ones
  task automatic av(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge ref_clk);
    avs_address <= a;
    avs_write <= wr;
    avs_read <= !wr;
    avs_writedata <= d;
    do begin
      @(posedge ref_clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 20);
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    if (n >= 20) chk("waitrequest", 32'h0, 32'h1);
  endtask

  task automatic clear_sticky();
    ss_clear <= 5'h1F;
    tick(1);
    ss_clear <= 5'h00;
    tick(2);
  endtask

  // Slot layout; sticky bits stand in the low five of slot 1 and are clear here
  function automatic logic [31:0] exp_word(input logic [3:0] i);
    case (i)
      4'h0: return {cfg.dev_csr[15:0], cfg.device_ctl_status_two};
      4'h1: return {cfg.slot_ctl, cfg.slot_sts[15:5], 5'h00};
      4'h2: return {cfg.link_csr[15:0], cfg.link_ctl_status_two[15:0]};
      4'h3: return {8'h00, cfg.prm_csr[15:0], cfg.root_csr[7:0]};
      4'h4: return {cfg.sec_csr[15:0], cfg.sec_bus, cfg.sub_bus};
      4'h5: return {12'h000, cfg.io_base};
      4'h6: return {12'h000, cfg.io_limit};
      4'h7: return {8'h00, cfg.nonprefetch_base, cfg.nonprefetch_limit};
      4'h8: return cfg.prefetch_base[31:0];
      4'h9: return {20'h00000, cfg.prefetch_base[43:32]};
      4'hA: return cfg.prefetch_limit[31:0];
      4'hB: return {20'h00000, cfg.prefetch_limit[43:32]};
      4'hC: return cfg.pm_csr;
      4'hD: return {cfg.extended_msg_irq_ctl, cfg.msg_irq_ctl};
      4'hE: return {8'h00, cfg.traffic_class_map};
      default: return {19'h00000, cfg.bus_dev};
    endcase
  endfunction

  task automatic t_round();
    logic [3:0] prev;
    prev = 4'h0;
    // Edge one after release still shows the reset word
    tick(1);
    for (int n = 0; n < 34; n++) begin
      tick(1);
      if (n > 0) chk("slot index", 32'(4'(prev + 4'h1)), 32'(link.cfg_slot_index));
      chk("slot word", exp_word(link.cfg_slot_index), link.cfg_mux_word);
      chk("status bit 0", 32'(cfg.sec_csr[4]), 32'(link.cfg_status_vector[0]));
      prev = link.cfg_slot_index;
    end
    $display("test round robin done");
  endtask

  task automatic t_sizes();
    logic [31:0] e;
    for (int c = 0; c < 8; c++) begin
      cfg.dev_csr[14:12] <= 3'(c);
      cfg.dev_csr[7:5] <= 3'(c);
      tick(2);
      // Fields sit in the word only while slot 0 is shown
      while (link.cfg_slot_index !== 4'h0) begin
        tick(1);
      end
      e = (c < 6) ? (32'h80 << c) : 32'h0;
      chk("read request bytes", e, 32'(mrrs));
      chk("payload bytes", e, 32'(mps));
      chk("size field in slot 0", 32'(c), 32'(link.cfg_mux_word[30:28]));
      chk("payload field in slot 0", 32'(c), 32'(link.cfg_mux_word[23:21]));
    end
    $display("test size codes done");
  endtask

  // Each pin alone must land in its own sticky bit
  task automatic t_events();
    int sbit[5] = '{0, 3, 2, 1, 4};
    av(1'b1, 8'h50, 32'h0000000F);
    for (int k = 0; k < 5; k++) begin
      pins[k] <= 1'b1;
      tick(6);
      chk("slot_sts", 32'(5'h01 << sbit[k]), 32'(ss));
      if (k == 4) chk("command done", 32'h1, 32'(link.cfg_status_vector[47]));
      pins[k] <= 1'b0;
      tick(6);
      clear_sticky();
      chk("slot_sts cleared", 32'h0, 32'(ss));
    end
    $display("test slot events done");
  endtask

  task automatic t_gating();
    slot_cap_enable <= 1'b0;
    pins[0] <= 1'b1;
    tick(6);
    chk("slot_sts gated", 32'h0, 32'(ss));
    slot_cap_enable <= 1'b1;
    root_port_mode <= 1'b0;
    tick(6);
    chk("slot_sts endpoint gated", 32'h0, 32'(ss));
    pins[0] <= 1'b0;
    tick(6);
    root_port_mode <= 1'b1;
    av(1'b1, 8'h50, 32'h0);
    pins <= 5'h1F;
    tick(6);
    chk("slot_event endpoint", 32'h0, 32'(link.slot_event));
    av(1'b1, 8'h50, 32'h1);
    tick(6);
    chk("slot_event bare slot", 32'h2, 32'(link.slot_event));
    pins <= 5'h00;
    tick(6);
    clear_sticky();
    $display("test event gating done");
  endtask

  task automatic t_irq_regs();
    av(1'b1, 8'h50, 32'h0000000F);
    av(1'b1, 8'h4C, 32'h1);
    av(1'b1, 8'h48, 32'h7);
    tick(1);
    chk("irq idle", 32'h0, 32'(irq));
    pins[4] <= 1'b1;
    tick(8);
    chk("irq raised", 32'h1, 32'(irq));
    av(1'b1, 8'h48, 32'h1);
    tick(1);
    chk("irq cleared", 32'h0, 32'(irq));
    av(1'b0, 8'h50, 32'h0);
    chk("control readback", 32'hF, rd);
    av(1'b0, 8'h60, 32'h0);
    chk("unmapped read", 32'h0, rd);
    av(1'b0, 8'h00, 32'h0);
    chk("shadow slot 0", exp_word(4'h0), rd);
    pins[4] <= 1'b0;
    tick(6);
    clear_sticky();
    $display("test interrupt and registers done");
  endtask

  // Main sequence
  initial begin
    ref_clk = 1'b0;
    rst = 1'b1;
    cfg = 488'({16{32'h5A3C96E1}});
    root_port_mode = 1'b1;
    slot_cap_enable = 1'b1;
    ss_clear = 5'h00;
    pins = 5'h00;
    avs_address = 8'h00;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    tick(10);
    rst <= 1'b0;
    t_round();
    t_sizes();
    t_events();
    t_gating();
    t_irq_regs();
    end_of_test();
  end
endmodule
